// [hw/tmr01_ext_irq.sv]
// timer 0/1 counters with external interrupt sensing, reached over the special function register bus
// What this block does
// - timer1 overflow sets its flag unless timer0 is in split mode; software or vectoring to its routine clears it
// - timer0 overflow sets its flag; software or vectoring to its routine clears it
// - timer1 counts only while its run bit is set, subject to gating
// - timer0 counts only while its run bit is set, subject to gating, except its split-mode high byte, which runs under timer1 run
// - ext irq1 flag set on chosen edge/level; vector clears it in edge mode
// - ext irq0 flag set on chosen edge/level; vector clears it in edge mode
// - ext irq1 type bit: 0 level, 1 edge; polarity from separate configuration
// - ext irq0 type bit: 0 level, 1 edge; polarity from separate configuration
// - timer1 gate set means it also needs ext irq1 input active
// - timer0 gate set means it also needs ext irq0 input active
// - timer1 counter select picks timer clock or falling edges of its pin
// - timer0 counter select picks timer clock or falling edges of its pin
// - timer1 modes: 13-bit, 16-bit, 8-bit auto-reload, inactive
// - timer0 modes: 13-bit, 16-bit, 8-bit auto-reload, two 8-bit timers
// - timer0 low byte register reads and writes count bits 7:0, resets zero
// - timer1 low byte register reads and writes count bits 7:0, resets zero
// - timer0 high byte register reads and writes count high bits, resets zero
// - timer1 high byte register holds the high count bits
// - clock-select picks prescaled or system clock in timer mode only; timer1's also clocks the split timer0 high byte in counter mode
module tmr01_ext_irq
  import tmr01_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  output logic      [7:0] sfrRdData,
  input  wire logic       timer0CountPin,
  input  wire logic       timer1CountPin,
  input  wire logic       extIrq0Input,
  input  wire logic       extIrq1Input,
  input  wire logic       extIrq0Polarity,
  input  wire logic       extIrq1Polarity,
  input  wire logic       timer0ClkSel,
  input  wire logic       timer1ClkSel,
  input  wire logic       prescaleTick,
  input  wire logic       vecTimer0,
  input  wire logic       vecTimer1,
  input  wire logic       vecExtIrq0,
  input  wire logic       vecExtIrq1,
  output logic            timer0OverflowFlag,
  output logic            timer1OverflowFlag,
  output logic            extIrq0Flag,
  output logic            extIrq1Flag
);

  tmr_state_s st_r;
  tmr_state_s st_nxt;

  // one count step: returns {overflow, high, low}
  function automatic logic [16:0] tmr_step(input logic [1:0] md, input logic [7:0] hi, input logic [7:0] lo);
    logic [16:0] res;
    res = {1'b0, hi, lo};
    case (md)
      TMR_MODE_13BIT: begin
        res[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == 5'h1f) begin
          res[15:8] = hi + 8'h01;
          res[16]   = (hi == 8'hff);
        end
      end
      TMR_MODE_16BIT: begin
        res = {1'b0, hi, lo} + 17'h00001;
      end
      // reload low byte from high byte
      TMR_MODE_RELD: begin
        res[7:0] = (lo == 8'hff) ? hi : lo + 8'h01;
        res[16]  = (lo == 8'hff);
      end
      default: begin
        res = {1'b0, hi, lo};
      end
    endcase
    return res;
  endfunction : tmr_step

  logic [3:0]  pinFall;
  logic [3:0]  pinRise;
  logic        int0Active;
  logic        int1Active;
  logic        run0;
  logic        run1;
  logic        tick0;
  logic        tick1;
  logic        tickSys1;
  logic        step0;
  logic        step1;
  logic        stepHi0;
  logic        ovf0;
  logic        ovf1;
  logic        edge0;
  logic        edge1;
  logic [1:0]  mode0;
  logic [1:0]  mode1;
  logic [16:0] next0;
  logic [16:0] next1;
  logic        wrCtrl;

  always_comb begin
    st_nxt = st_r;
    // two-stage synchroniser, edges taken from the settled stages
    st_nxt.syncA = {extIrq1Input, extIrq0Input, timer1CountPin, timer0CountPin};
    st_nxt.syncB = st_r.syncA;
    st_nxt.syncC = st_r.syncB;
    pinFall = st_r.syncC & ~st_r.syncB;
    pinRise = ~st_r.syncC & st_r.syncB;

    mode0 = st_r.mode[TMR_B_M0HI:TMR_B_M0LO];
    mode1 = st_r.mode[TMR_B_M1HI:TMR_B_M1LO];

    int0Active = (st_r.syncB[TMR_P_XIN0] == extIrq0Polarity);
    int1Active = (st_r.syncB[TMR_P_XIN1] == extIrq1Polarity);
    // edge means entering the active level
    edge0 = extIrq0Polarity ? pinRise[TMR_P_XIN0] : pinFall[TMR_P_XIN0];
    // edge means entering the active level
    edge1 = extIrq1Polarity ? pinRise[TMR_P_XIN1] : pinFall[TMR_P_XIN1];

    run0 = st_r.ctrl[TMR_B_RUN0] & (~st_r.mode[TMR_B_GTE0] | int0Active);
    run1 = st_r.ctrl[TMR_B_RUN1] & (~st_r.mode[TMR_B_GTE1] | int1Active);

    // clock select ignored in counter mode
    tick0 = st_r.mode[TMR_B_CSEL0] ? pinFall[TMR_P_CNT0] : (timer0ClkSel | prescaleTick);
    // clock select ignored in counter mode
    tick1 = st_r.mode[TMR_B_CSEL1] ? pinFall[TMR_P_CNT1] : (timer1ClkSel | prescaleTick);
    tickSys1 = timer1ClkSel | prescaleTick;

    step0 = run0 & tick0;
    step1 = run1 & tick1 & (mode1 != TMR_MODE_SPLIT);
    // split high byte runs on the timer clock under timer1 run
    stepHi0 = (mode0 == TMR_MODE_SPLIT) & st_r.ctrl[TMR_B_RUN1] & tickSys1;

    next0 = tmr_step(mode0, st_r.t0Hi, st_r.t0Lo);
    if (mode0 == TMR_MODE_SPLIT) begin
      next0 = {(st_r.t0Lo == 8'hff), st_r.t0Hi, st_r.t0Lo + 8'h01};
    end
    next1 = tmr_step(mode1, st_r.t1Hi, st_r.t1Lo);

    ovf0 = step0 & next0[16];
    // a timer1 overflow is hidden while timer0 borrows the flag in split mode
    ovf1 = (step1 & next1[16] & (mode0 != TMR_MODE_SPLIT)) | (stepHi0 & (st_r.t0Hi == 8'hff));

    if (step0) begin
      st_nxt.t0Lo = next0[7:0];
      if (mode0 != TMR_MODE_SPLIT) begin
        st_nxt.t0Hi = next0[15:8];
      end
    end
    if (stepHi0) begin
      st_nxt.t0Hi = st_r.t0Hi + 8'h01;
    end
    if (step1) begin
      st_nxt.t1Lo = next1[7:0];
      st_nxt.t1Hi = next1[15:8];
    end

    // a software write to a count byte wins over the count step
    if (sfrWrEn) begin
      case (sfrAddr)
        TMR_OFS_MODE: st_nxt.mode = sfrWrData;
        TMR_OFS_T0LO: st_nxt.t0Lo = sfrWrData;
        TMR_OFS_T0HI: st_nxt.t0Hi = sfrWrData;
        TMR_OFS_T1LO: st_nxt.t1Lo = sfrWrData;
        TMR_OFS_T1HI: st_nxt.t1Hi = sfrWrData;
        default: st_nxt.mode = st_r.mode;
      endcase
    end

    // control byte: software write or vector clear first, hardware set on top
    wrCtrl = sfrWrEn & (sfrAddr == TMR_OFS_CTRL);
    if (wrCtrl) begin
      st_nxt.ctrl = sfrWrData;
    end
    if (vecTimer1) begin
      st_nxt.ctrl[TMR_B_OVF1] = 1'b0;
    end
    if (vecTimer0) begin
      st_nxt.ctrl[TMR_B_OVF0] = 1'b0;
    end
    // vector clears only in edge mode
    if (vecExtIrq0 & st_r.ctrl[TMR_B_XTY0]) begin
      st_nxt.ctrl[TMR_B_XFL0] = 1'b0;
    end
    // vector clears only in edge mode
    if (vecExtIrq1 & st_r.ctrl[TMR_B_XTY1]) begin
      st_nxt.ctrl[TMR_B_XFL1] = 1'b0;
    end
    if (ovf1) begin
      st_nxt.ctrl[TMR_B_OVF1] = 1'b1;
    end
    if (ovf0) begin
      st_nxt.ctrl[TMR_B_OVF0] = 1'b1;
    end
    if (st_r.ctrl[TMR_B_XTY0] ? edge0 : int0Active) begin
      st_nxt.ctrl[TMR_B_XFL0] = 1'b1;
    end
    if (st_r.ctrl[TMR_B_XTY1] ? edge1 : int1Active) begin
      st_nxt.ctrl[TMR_B_XFL1] = 1'b1;
    end

    // read data is registered, answering one cycle after the address
    case (sfrAddr)
      TMR_OFS_CTRL: st_nxt.rdData = st_r.ctrl;
      TMR_OFS_MODE: st_nxt.rdData = st_r.mode;
      TMR_OFS_T0LO: st_nxt.rdData = st_r.t0Lo;
      TMR_OFS_T0HI: st_nxt.rdData = st_r.t0Hi;
      TMR_OFS_T1LO: st_nxt.rdData = st_r.t1Lo;
      TMR_OFS_T1HI: st_nxt.rdData = st_r.t1Hi;
      default:      st_nxt.rdData = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r.ctrl   <= TMR_RST_CTRL;
      st_r.mode   <= TMR_RST_MODE;
      st_r.t0Lo   <= TMR_RST_COUNT;
      st_r.t0Hi   <= TMR_RST_COUNT;
      st_r.t1Lo   <= TMR_RST_COUNT;
      st_r.t1Hi   <= TMR_RST_COUNT;
      st_r.syncA  <= TMR_SYNC_RST;
      st_r.syncB  <= TMR_SYNC_RST;
      st_r.syncC  <= TMR_SYNC_RST;
      st_r.rdData <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfrRdData          = st_r.rdData;
  assign timer0OverflowFlag = st_r.ctrl[TMR_B_OVF0];
  assign timer1OverflowFlag = st_r.ctrl[TMR_B_OVF1];
  assign extIrq0Flag        = st_r.ctrl[TMR_B_XFL0];
  assign extIrq1Flag        = st_r.ctrl[TMR_B_XFL1];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic noWr;
  assign noWr = !sfrWrEn;

  AST_OVF0_SET: assert property (ovf0 |=> timer0OverflowFlag)
    else $error("timer0 overflow did not set its flag");
  AST_OVF1_CLR: assert property (vecTimer1 && !ovf1 && noWr |=> !timer1OverflowFlag)
    else $error("timer1 flag not cleared on vector");
  AST_RUN0: assert property (!st_r.ctrl[TMR_B_RUN0] && noWr && mode0 != TMR_MODE_SPLIT
      |=> $stable(st_r.t0Lo) && $stable(st_r.t0Hi))
    else $error("timer0 moved while stopped");
  AST_RUN1: assert property (!st_r.ctrl[TMR_B_RUN1] && noWr |=> $stable({st_r.t1Hi, st_r.t1Lo}))
    else $error("timer1 moved while stopped");
  AST_TIMER0_GATE: assert property (st_r.mode[TMR_B_GTE0] && !int0Active && noWr |=> $stable(st_r.t0Lo))
    else $error("gated timer0 counted with input inactive");
  AST_XFL0_EDGE: assert property (st_r.ctrl[TMR_B_XTY0] && edge0 |=> extIrq0Flag)
    else $error("edge on ext irq0 not flagged");
  AST_XFL1_LEVEL: assert property (!st_r.ctrl[TMR_B_XTY1] && int1Active |=> extIrq1Flag [*1])
    else $error("active level on ext irq1 not flagged");
  AST_RELOAD0: assert property (step0 && mode0 == TMR_MODE_RELD && st_r.t0Lo == 8'hff && noWr
      |=> st_r.t0Lo == $past(st_r.t0Hi) && timer0OverflowFlag)
    else $error("timer0 reload wrong");
  AST_CNT0: assert property (st_r.mode[TMR_B_CSEL0] && run0 && mode0 == TMR_MODE_16BIT && noWr
      && !$past(pinFall[TMR_P_CNT0]) && !pinFall[TMR_P_CNT0] |=> $stable(st_r.t0Lo))
    else $error("counter mode counted without a pin edge");
  AST_M3T1: assert property (mode1 == TMR_MODE_SPLIT && noWr |=> $stable({st_r.t1Hi, st_r.t1Lo}))
    else $error("timer1 counted in inactive mode");

  COV_OVF0: cover property (ovf0 ##1 vecTimer0);
  COV_SPLIT: cover property (mode0 == TMR_MODE_SPLIT && stepHi0 && st_r.t0Hi == 8'hff);
  COV_EDGE1: cover property (st_r.ctrl[TMR_B_XTY1] && edge1 ##1 vecExtIrq1);
  COV_RELD1: cover property (step1 && mode1 == TMR_MODE_RELD && st_r.t1Lo == 8'hff);
endmodule : tmr01_ext_irq

// [hw/tmr01_pkg.sv]
// constants and types for the timer 0/1 and external interrupt block
package tmr01_pkg;
  localparam logic [7:0] TMR_OFS_CTRL  = 8'h88;
  localparam logic [7:0] TMR_OFS_MODE  = 8'h89;
  localparam logic [7:0] TMR_OFS_T0LO  = 8'h8a;
  localparam logic [7:0] TMR_OFS_T1LO  = 8'h8b;
  localparam logic [7:0] TMR_OFS_T0HI  = 8'h8c;
  localparam logic [7:0] TMR_OFS_T1HI  = 8'h8d;

  localparam logic [7:0] TMR_RST_CTRL  = 8'h00;
  localparam logic [7:0] TMR_RST_MODE  = 8'h00;
  localparam logic [7:0] TMR_RST_COUNT = 8'h00;

  // timer_irq_control bit positions
  localparam int TMR_B_OVF1 = 7;
  localparam int TMR_B_RUN1 = 6;
  localparam int TMR_B_OVF0 = 5;
  localparam int TMR_B_RUN0 = 4;
  localparam int TMR_B_XFL1 = 3;
  localparam int TMR_B_XTY1 = 2;
  localparam int TMR_B_XFL0 = 1;
  localparam int TMR_B_XTY0 = 0;

  // timer_mode_select bit positions
  localparam int TMR_B_GTE1  = 7;
  localparam int TMR_B_CSEL1 = 6;
  localparam int TMR_B_M1HI  = 5;
  localparam int TMR_B_M1LO  = 4;
  localparam int TMR_B_GTE0  = 3;
  localparam int TMR_B_CSEL0 = 2;
  localparam int TMR_B_M0HI  = 1;
  localparam int TMR_B_M0LO  = 0;

  // operating modes of the two-bit mode fields
  localparam logic [1:0] TMR_MODE_13BIT = 2'h0;
  localparam logic [1:0] TMR_MODE_16BIT = 2'h1;
  localparam logic [1:0] TMR_MODE_RELD  = 2'h2;
  localparam logic [1:0] TMR_MODE_SPLIT = 2'h3;

  // pin index in the synchroniser vectors
  localparam int TMR_P_CNT0 = 0;
  localparam int TMR_P_CNT1 = 1;
  localparam int TMR_P_XIN0 = 2;
  localparam int TMR_P_XIN1 = 3;
  localparam logic [3:0] TMR_SYNC_RST = 4'hf;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] t0Lo;
    logic [7:0] t0Hi;
    logic [7:0] t1Lo;
    logic [7:0] t1Hi;
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [3:0] syncC;
    logic [7:0] rdData;
  } tmr_state_s;
endpackage : tmr01_pkg

// [tb/tmr_cpu.sv]
// cpu side model: register bus cycles and vector pulses toward the timer block
module tmr_cpu
  import tmr01_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] sfrRdData,
  output logic      [7:0] sfrAddr,
  output logic            sfrWrEn,
  output logic      [7:0] sfrWrData,
  output logic      [3:0] vecPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sfrAddr = 8'h00;
    sfrWrEn = 1'b0;
    sfrWrData = 8'h00;
    vecPulse = 4'h0;
  end
  // released data is inverted so a stale byte never passes for a fresh one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr <= a;
    sfrWrEn <= 1'b1;
    sfrWrData <= d;
    @(posedge ref_clk);
    sfrWrEn <= 1'b0;
    sfrWrData <= ~d;
    @(posedge ref_clk);
  endtask : wr
  // read data lags the address by one edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfrAddr <= a;
    repeat (2) @(posedge ref_clk);
    d = sfrRdData;
  endtask : rd
  task automatic vec(input int n);
    vecPulse <= 4'(1 << n);
    @(posedge ref_clk);
    vecPulse <= 4'h0;
    repeat (2) @(posedge ref_clk);
  endtask : vec
endmodule : tmr_cpu

// [tb/tb.sv]
// self-checking bench for the timer 0/1 and external interrupt block
module tb
  import tmr01_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] OFS [7] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e};
  logic        ref_clk, rst_n, tick, sfrWrEn, g, a, p;
  logic [1:0]  pin, irqIn, pol, clkSel, tf, ef, md;
  logic [7:0]  sfrAddr, sfrWrData, sfrRdData, rv, lo, hi, lA, hA;
  logic [3:0]  vecPulse;
  logic [16:0] e;
  int          errTotal, checkCount, n;
  tmr01_ext_irq i_tmr01_ext_irq (.ref_clk, .rst_n, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdData,
    .timer0CountPin(pin[0]), .timer1CountPin(pin[1]), .extIrq0Input(irqIn[0]), .extIrq1Input(irqIn[1]),
    .extIrq0Polarity(pol[0]), .extIrq1Polarity(pol[1]), .timer0ClkSel(clkSel[0]),
    .timer1ClkSel(clkSel[1]), .prescaleTick(tick), .vecTimer0(vecPulse[0]), .vecTimer1(vecPulse[1]),
    .vecExtIrq0(vecPulse[2]), .vecExtIrq1(vecPulse[3]), .timer0OverflowFlag(tf[0]),
    .timer1OverflowFlag(tf[1]), .extIrq0Flag(ef[0]), .extIrq1Flag(ef[1]));
  tmr_cpu i_tmr_cpu (.ref_clk, .sfrRdData, .sfrAddr, .sfrWrEn, .sfrWrData, .vecPulse);
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : giveVerdict
  task automatic chkB(string s, logic [7:0] x, logic [7:0] v);
    checkCount++;
    if (v !== x) begin
      errTotal++;
      $display("BAD %s exp %h got %h", s, x, v);
    end
  endtask : chkB
  task automatic chkF(string s, logic x, logic v);
    checkCount++;
    if (v !== x) begin
      errTotal++;
      $display("BAD %s exp %b got %b", s, x, v);
    end
  endtask : chkF
  task automatic cyc(int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    i_tmr_cpu.wr(ad, d);
  endtask : wr
  task automatic rc(string s, logic [7:0] ad, logic [7:0] x);
    i_tmr_cpu.rd(ad, rv);
    chkB(s, x, rv);
  endtask : rc
  // pins idle high, so a low pulse gives one falling edge
  task automatic pulse(int t);
    pin[t] <= 1'b0;
    cyc(3);
    pin[t] <= 1'b1;
    cyc(6);
  endtask : pulse
  // expected {overflow, high, low} after one count step
  function automatic logic [16:0] nxt(int t, logic [1:0] m, logic [7:0] l, logic [7:0] h);
    case (m)
      2'h0: return (l[4:0] == 5'h1f) ? {&h, h + 8'h01, l[7:5], 5'h00} : {1'b0, h, l + 8'h01};
      2'h1: return {1'b0, h, l} + 17'h00001;
      2'h2: return (l == 8'hff) ? {1'b1, h, h} : {1'b0, h, l + 8'h01};
      default: return (t == 1) ? {1'b0, h, l} : {&l, h, l + 8'h01};
    endcase
  endfunction : nxt
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    errTotal++;
    giveVerdict();
  end
  initial begin
    rst_n = 1'b0;
    pin = 2'h3;
    // synchronisers come out of reset high, so idle-high inputs must read inactive
    irqIn = 2'h3;
    pol = 2'h0;
    clkSel = 2'h0;
    tick = 1'b0;
    void'($urandom(47334));
    cyc(2);
    rst_n <= 1'b1;
    cyc(1);
    foreach (OFS[i]) rc("reset", OFS[i], 8'h00);
    for (int i = 1; i < 7; i++) begin
      lo = $urandom;
      wr(OFS[i], lo);
      rc("rw", OFS[i], (i == 6) ? 8'h00 : lo);
    end
    $display("test registers done");
    for (int t = 0; t < 2; t++) begin
      lA = t ? TMR_OFS_T1LO : TMR_OFS_T0LO;
      hA = t ? TMR_OFS_T1HI : TMR_OFS_T0HI;
      for (int k = 0; k < 12; k++) begin
        md = 2'(k % 4);
        lo = ($urandom % 2) ? 8'hff : 8'($urandom);
        hi = ($urandom % 2) ? 8'hff : 8'($urandom);
        g = $urandom;
        a = $urandom;
        p = $urandom;
        irqIn[t] <= a;
        pol[t] <= p;
        clkSel[t] <= $urandom;
        wr(TMR_OFS_CTRL, 8'h00);
        wr(TMR_OFS_MODE, t ? {g, 1'b1, md, 4'h1} : {4'h0, g, 1'b1, md});
        wr(lA, lo);
        wr(hA, hi);
        pulse(t);
        wr(TMR_OFS_CTRL, 8'(8'h10 << 2 * t));
        pulse(t);
        e = (!g || a == p) ? nxt(t, md, lo, hi) : {1'b0, hi, lo};
        chkF("overflow", e[16], tf[t]);
        rc("count low", lA, e[7:0]);
        rc("count high", hA, e[15:8]);
        i_tmr_cpu.vec(t);
        chkF("overflow vec", 1'b0, tf[t]);
      end
      clkSel[t] <= 1'b0;
      n = $urandom_range(8, 1);
      wr(TMR_OFS_MODE, t ? 8'h10 : 8'h01);
      wr(lA, 8'h00);
      wr(TMR_OFS_CTRL, 8'(8'h10 << 2 * t));
      repeat (n) begin
        tick <= 1'b1;
        cyc(1);
        tick <= 1'b0;
        cyc(1);
      end
      wr(TMR_OFS_CTRL, 8'h00);
      rc("ticks", lA, 8'(n));
    end
    wr(TMR_OFS_MODE, 8'h03);
    wr(TMR_OFS_T0HI, 8'hff);
    wr(TMR_OFS_CTRL, 8'h40);
    tick <= 1'b1;
    cyc(1);
    tick <= 1'b0;
    cyc(1);
    chkF("split overflow", 1'b1, tf[1]);
    rc("split high", TMR_OFS_T0HI, 8'h00);
    wr(TMR_OFS_CTRL, 8'h00);
    $display("test timers done");
    for (int i = 0; i < 2; i++) begin
      for (int ty = 0; ty < 2; ty++) begin
        g = $urandom;
        pol[i] <= g;
        irqIn[i] <= ~g;
        cyc(5);
        wr(TMR_OFS_CTRL, 8'(ty << 2 * i));
        irqIn[i] <= g;
        cyc(5);
        chkF("irq set", 1'b1, ef[i]);
        i_tmr_cpu.vec(2 + i);
        chkF("irq vec", 1'(!ty), ef[i]);
        irqIn[i] <= ~g;
        cyc(5);
        wr(TMR_OFS_CTRL, 8'(ty << 2 * i));
        chkF("irq idle", 1'b0, ef[i]);
      end
    end
    $display("test interrupts done");
    giveVerdict();
  end
endmodule : tb
